// File: verification/tb_top.sv
/*
  Self-checking bench for the multi-match pulse-width timer: register
  access, pulse duty per output, match release, prescaler and match actions.
  Assumes the timer alone on one 100 MHz clock, driven as a wishbone master.
*/
`timescale 1ns/1ps
module tb_top
  import mmpt_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [5:0]  pwm_o;
  int          bad_count = 0;
  int          tests_run = 0;
  int          hi [6];
  logic [31:0] rd;
  logic [31:0] rd2;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  mmpt_timer u_mmpt_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cyc_i (cyc_i),
    .stb_i (stb_i),
    .we_i  (we_i),
    .adr_i (adr_i),
    .sel_i (sel_i),
    .dat_i (dat_i),
    .dat_o (dat_o),
    .ack_o (ack_o),
    .pwm_o (pwm_o)
  );

  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // one classic cycle; request held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rdw(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask : rdw

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check32

  // high-clock count per output over n clocks; unknown never counts as high
  task automatic chk_duty(input int n, input int e [6]);
    hi = '{default: 0};
    repeat (n) begin
      @(posedge clk_i);
      for (int k = 0; k < 6; k++) begin
        if (pwm_o[k] === 1'b1) hi[k]++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      check32(32'(hi[k]), 32'(e[k]));
    end
  endtask : chk_duty

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rdw(a, q);
    check32(q, exp);
  endtask : rd_chk

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place, read-only counter
    rd_chk(OFS_CTRL, RST_WORD);
    rd_chk(OFS_FLAGS, RST_WORD);
    rd_chk(OFS_PWMCTL, RST_WORD);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_0005);
    rd_chk(OFS_COUNT, 32'h0000_0000);
    // byte lanes merge into the prescale limit
    wr(OFS_PSCALE, 32'h1122_3344);
    wb_cycle(1'b1, OFS_PSCALE, 32'hAABB_CCDD, 4'h2, rd);
    rd_chk(OFS_PSCALE, 32'h1122_CC44);
    wr(OFS_PSCALE, 32'h0000_0000);
    // matches written while pulse mode is off load at once
    wr(OFS_MATCH0, 32'h0000_0009);
    wr(OFS_MATCH0 + 8'h04, 32'h0000_0003);
    wr(OFS_MATCH0 + 8'h08, 32'h0000_0007);
    wr(OFS_MATCH0 + 8'h0C, 32'h0000_0008);
    wr(OFS_MATCH0 + 8'h10, 32'h0000_0005);
    wr(OFS_MATCH0 + 8'h14, 32'h0000_0000);
    wr(OFS_MATCH0 + 8'h18, 32'h0000_0005);
    wr(OFS_PWMCTL, 32'h0000_3F0A);
    wr(OFS_CTRL, 32'h0000_0009);
    repeat (25) @(posedge clk_i);
    // period 10: single 1,3,6; double 2 positive, 4 negative; 5 constant low
    chk_duty(10, '{4, 4, 9, 7, 0, 6});
    // new edge stays pending until released
    wr(OFS_MATCH0 + 8'h04, 32'h0000_0006);
    rd_chk(OFS_MATCH0 + 8'h04, 32'h0000_0006);
    repeat (25) @(posedge clk_i);
    chk_duty(10, '{4, 4, 9, 7, 0, 6});
    wr(OFS_LATCH, 32'h0000_0002);
    repeat (25) @(posedge clk_i);
    rd_chk(OFS_LATCH, 32'h0000_0000);
    chk_duty(10, '{7, 1, 9, 7, 0, 6});
    // prescale limit 1 doubles every width and the period
    wr(OFS_PSCALE, 32'h0000_0001);
    repeat (50) @(posedge clk_i);
    chk_duty(20, '{14, 2, 18, 14, 0, 12});
    // plain timer: stop action on match 2, outputs quiet
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_PSCALE, 32'h0000_0000);
    wr(OFS_MCTL, 32'h0000_0100);
    wr(OFS_MATCH0, 32'h0000_0064);
    wr(OFS_MATCH0 + 8'h08, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk_i);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_FLAGS, 32'h0000_0000);
    chk_duty(10, '{0, 0, 0, 0, 0, 0});
    rdw(OFS_COUNT, rd);
    rdw(OFS_COUNT, rd2);
    check32(rd2, rd);
    check32({31'h0, rd == 32'h5 || rd == 32'h6}, 32'h1);
    // reset and interrupt on match 2; flag cleared by writing one
    wr(OFS_CTRL, 32'h0000_0002); // hold restarts the count below match 2
    wr(OFS_MCTL, 32'h0000_00C0);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk_i);
    rd_chk(OFS_FLAGS, 32'h0000_0004);
    rdw(OFS_COUNT, rd);
    check32({31'h0, rd <= 32'h5}, 32'h1);
    wr(OFS_CTRL, 32'h0000_0002);
    wr(OFS_FLAGS, 32'h0000_0004);
    rd_chk(OFS_FLAGS, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tb_top

// File: verilog/mmpt_pkg.sv
/*
  Constants for the multi-match pulse-width timer: register byte offsets,
  field positions and reset values shared by the timer and its prescaler.
  Assumes a 32-bit classic Wishbone slave port decoding adr[7:2].
*/
package mmpt_pkg;

  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT   = 6;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS  = 8'h00; // interrupt flags, write one to clear
  localparam logic [7:0] OFS_CTRL   = 8'h04; // run, hold, pulse mode
  localparam logic [7:0] OFS_COUNT  = 8'h08; // main counter, read only
  localparam logic [7:0] OFS_PSCALE = 8'h0C; // prescale limit
  localparam logic [7:0] OFS_PCOUNT = 8'h10; // prescale count, read only
  localparam logic [7:0] OFS_MCTL   = 8'h14; // three action bits per match
  localparam logic [7:0] OFS_MATCH0 = 8'h18; // period_match_register, then 1..6
  localparam logic [7:0] OFS_PWMCTL = 8'h34; // edge select and output enables
  localparam logic [7:0] OFS_LATCH  = 8'h38; // release bits, one per match

  // control fields
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_PWM  = 3;

  // per-match action bits within a three-bit group
  localparam int MCTL_IRQ   = 0;
  localparam int MCTL_RESET = 1;
  localparam int MCTL_STOP  = 2;
  localparam int MCTL_W     = 3;

  // pulse control fields
  localparam int PWMCTL_DBL = 0; // bits 5:0, output k+1 double-edge when set, except output 1, which is always single-edge
  localparam int PWMCTL_OEN = 8; // bits 13:8, output k+1 enabled

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0]  RST_CTRL = 3'h0;

endpackage : mmpt_pkg

// File: verilog/mmpt_prescaler.sv
/*
  Prescaler for the pulse-width timer: counts clock cycles up to a
  programmable limit and emits a one-cycle tick on each wrap.
  Assumes run and hold come from registers on the same clock.
*/
`timescale 1ns/1ps
module mmpt_prescaler
  import mmpt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        run_i,
  input  wire logic        hold_i,
  input  wire logic [31:0] limit_i,
  // status
  output logic             tick_o,
  output logic [31:0]      count_o
);

  typedef struct packed {
    logic [31:0] count;
  } mmpt_pre_s;

  mmpt_pre_s st;
  mmpt_pre_s next_st;

  // wrap when the count reaches the limit; limit zero ticks every cycle
  assign tick_o  = run_i && !hold_i && (st.count == limit_i);
  assign count_o = st.count;

  // next count
  always_comb begin
    next_st = st;
    if (hold_i) begin
      next_st.count = RST_WORD;
    end else if (tick_o) begin
      next_st.count = RST_WORD;
    end else if (run_i) begin
      next_st.count = st.count + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  chk_prescale_wrap : assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> (count_o == 32'h0000_0000))
    else $error("prescaler did not restart after tick");

endmodule : mmpt_prescaler

// File: verilog/mmpt_timer.sv
/*
  Multi-match pulse-width timer: 32-bit counter behind a prescaler, seven
  match registers with shadow copies, match actions, interrupt flags and
  six pulse outputs. Registers sit on a classic Wishbone slave.
  Assumes a single 100 MHz clock and a synchronous active-high reset;
  the interrupt flags are status only, no interrupt line leaves the block.
*/
`timescale 1ns/1ps
module mmpt_timer
  import mmpt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // pulse outputs, bit k is output k+1
  output logic [5:0]       pwm_o
);

  // whole state in one record so reset and register stay one process
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic                  run;
    logic                  hold;
    logic                  pwm;
    logic [31:0]           count;
    logic [31:0]           pscale;
    logic [20:0]           mctl;
    logic [6:0]            flags;
    logic [5:0]            dbl;
    logic [5:0]            oen;
    logic [6:0]            latch;
    logic [6:0][31:0]      shadow;
    logic [6:0][31:0]      act;
    logic [5:0]            out;
  } mmpt_state_s;

  mmpt_state_s st;
  mmpt_state_s next_st;

  logic        tick;
  logic [31:0] pcount;
  logic [6:0]  hit;
  logic [6:0]  hit_irq;
  logic [6:0]  hit_rst;
  logic [6:0]  hit_stop;
  logic        wr_take;
  logic [5:0]  set_out;
  logic [5:0]  clr_out;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : wb_merge

  // match register decode: valid flag and index, used for read and write
  function automatic logic [3:0] match_dec(input logic [7:0] adr);
    logic [3:0] res;
    res = 4'h0;
    for (int m = 0; m < NUM_MATCH; m++) begin
      if (adr[7:2] == 6'((int'(OFS_MATCH0) + 4*m) >> 2)) begin
        res = {1'b1, 3'(m)};
      end
    end
    return res;
  endfunction : match_dec

  mmpt_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (st.run),
    .hold_i  (st.hold),
    .limit_i (st.pscale),
    .tick_o  (tick),
    .count_o (pcount)
  );

  // match events only on a counter step, so each value matches once
  genvar gm;
  generate
    for (gm = 0; gm < NUM_MATCH; gm++) begin : g_hit
      assign hit[gm]      = tick && (st.count == st.act[gm]);
      assign hit_irq[gm]  = hit[gm] && st.mctl[gm*MCTL_W + MCTL_IRQ];
      assign hit_rst[gm]  = hit[gm] && st.mctl[gm*MCTL_W + MCTL_RESET];
      assign hit_stop[gm] = hit[gm] && st.mctl[gm*MCTL_W + MCTL_STOP];
    end
  endgenerate

  // edge sources per output; clear wins so equal edges give a low output
  genvar go;
  generate
    for (go = 0; go < NUM_OUT; go++) begin : g_edge
      if (go == 0) begin : g_single_only
        assign set_out[go] = hit[0] && (st.act[1] != RST_WORD);
      end else begin : g_either
        assign set_out[go] = st.dbl[go] ? hit[go]
                                        : hit[0] && (st.act[go+1] != RST_WORD);
      end
      assign clr_out[go] = hit[go+1];
    end
  endgenerate

  // write is taken on the edge where the master sees ack
  assign wr_take = cyc_i && stb_i && we_i && st.ack;

  // next state
  always_comb begin
    logic [3:0]  mdec;
    logic [31:0] wdat;
    mdec = match_dec(adr_i);
    wdat = RST_WORD;
    next_st = st;

    // wishbone answer one cycle after the request, dropped the cycle after
    next_st.ack   = cyc_i && stb_i && !st.ack;
    next_st.rdata = RST_WORD;
    if (cyc_i && stb_i && !we_i && !st.ack) begin
      unique case (adr_i[7:2])
        OFS_FLAGS[7:2]:  next_st.rdata = {25'h0, st.flags};
        OFS_CTRL[7:2]:   next_st.rdata = {28'h0, st.pwm, 1'b0, st.hold, st.run};
        OFS_COUNT[7:2]:  next_st.rdata = st.count;
        OFS_PSCALE[7:2]: next_st.rdata = st.pscale;
        OFS_PCOUNT[7:2]: next_st.rdata = pcount;
        OFS_MCTL[7:2]:   next_st.rdata = {11'h0, st.mctl};
        OFS_PWMCTL[7:2]: next_st.rdata = {18'h0, st.oen, 2'h0, st.dbl};
        OFS_LATCH[7:2]:  next_st.rdata = {25'h0, st.latch};
        default: begin
          if (mdec[3]) begin
            next_st.rdata = st.shadow[mdec[2:0]];
          end
        end
      endcase
    end

    // counter: reset on any resetting match or a pulse-mode period match, step on other ticks
    if (st.hold) begin
      next_st.count = RST_WORD;
    end else if (tick) begin
      if ((|hit_rst) || (st.pwm && hit[0])) begin
        next_st.count = RST_WORD;
      end else begin
        next_st.count = st.count + 32'h0000_0001;
      end
    end
    // a stop hit still lets its own step land, so a stopped count rests one past
    if (|hit_stop) begin
      next_st.run = 1'b0;
    end

    // flags: hardware set beats a same-cycle software clear
    next_st.flags = st.flags | hit_irq;

    // pulse outputs; in plain timer mode they stay low
    for (int k = 0; k < NUM_OUT; k++) begin
      if (!st.pwm || !st.oen[k]) begin
        next_st.out[k] = 1'b0;
      end else if (clr_out[k]) begin
        next_st.out[k] = 1'b0;
      end else if (set_out[k]) begin
        next_st.out[k] = 1'b1;
      end
    end

    // shadow release: in pulse mode only at the period match, so a cycle never mixes values
    for (int m = 0; m < NUM_MATCH; m++) begin
      if (!st.pwm) begin
        next_st.act[m] = st.shadow[m];
      end else if (hit[0] && st.latch[m]) begin
        next_st.act[m]   = st.shadow[m];
        next_st.latch[m] = 1'b0;
      end
    end

    // register writes
    if (wr_take) begin
      unique case (adr_i[7:2])
        OFS_FLAGS[7:2]: begin
          wdat = wb_merge(RST_WORD, dat_i, sel_i);
          next_st.flags = (st.flags & ~wdat[6:0]) | hit_irq;
        end
        OFS_CTRL[7:2]: begin
          wdat = wb_merge({28'h0, st.pwm, 1'b0, st.hold, st.run}, dat_i, sel_i);
          next_st.run  = wdat[CTRL_RUN];
          next_st.hold = wdat[CTRL_HOLD];
          next_st.pwm  = wdat[CTRL_PWM];
        end
        OFS_PSCALE[7:2]: begin
          next_st.pscale = wb_merge(st.pscale, dat_i, sel_i);
        end
        OFS_MCTL[7:2]: begin
          wdat = wb_merge({11'h0, st.mctl}, dat_i, sel_i);
          next_st.mctl = wdat[20:0];
        end
        OFS_PWMCTL[7:2]: begin
          wdat = wb_merge({18'h0, st.oen, 2'h0, st.dbl}, dat_i, sel_i);
          next_st.dbl = wdat[PWMCTL_DBL +: 6];
          next_st.oen = wdat[PWMCTL_OEN +: 6];
        end
        OFS_LATCH[7:2]: begin
          wdat = wb_merge(RST_WORD, dat_i, sel_i);
          next_st.latch = next_st.latch | wdat[6:0];
        end
        default: begin
          if (mdec[3]) begin
            next_st.shadow[mdec[2:0]] = wb_merge(st.shadow[mdec[2:0]], dat_i, sel_i);
          end
        end
      endcase
    end
  end

  // state register; all control state clears on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign pwm_o = st.out;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_wb_ack_single : assert property (
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  chk_period_restart : assert property (
    (st.pwm && hit[0] && !st.hold) |=> (st.count == 32'h0000_0000))
    else $error("period match did not restart the counter");

  chk_stop_on_match : assert property (
    (|hit_stop && !wr_take) |=> !st.run)
    else $error("stop action left the counter running");

  chk_flag_latch : assert property (
    (|hit_irq) |=> ((st.flags & $past(hit_irq)) == $past(hit_irq)))
    else $error("interrupt flag not latched or lost");

  chk_single_rise : assert property (
    (st.pwm && st.oen[0] && hit[0] && !hit[1] && st.act[1] != 32'h0) |=> pwm_o[0])
    else $error("single output not high at cycle start");

  chk_const_low : assert property (
    (st.pwm && !st.dbl[4] && st.act[5] == 32'h0 && !pwm_o[4]) |=> !pwm_o[4])
    else $error("constant low output went high");

  chk_double_rise : assert property (
    (st.pwm && st.oen[1] && st.dbl[1] && hit[1] && !hit[2]) |=> pwm_o[1])
    else $error("double output missed its rising edge");

  chk_shadow_hold : assert property (
    (st.pwm && !hit[0]) |=> (st.act == $past(st.act)))
    else $error("active match changed outside the period match");

  chk_timer_mode : assert property (
    !st.pwm |=> (pwm_o == 6'h00))
    else $error("pulse output active in timer mode");

  // edge, shadow, flag and counting checks; they watch internal state
  // rather than pin duty counts, so a wrong field shows up at the edge where it
  // goes wrong instead of cycles later in a duty count
  chk_single_fall : assert property (
    (st.pwm && st.oen[0] && hit[1]) |=> !pwm_o[0])
    else $error("single output missed its falling edge");

  chk_single_start : assert property (
    (st.pwm && st.oen[5] && !st.dbl[5] && hit[0] && !hit[6] && st.act[6] != 32'h0) |=> pwm_o[5])
    else $error("last single output not high at cycle start");

  chk_double_fall : assert property (
    (st.pwm && st.dbl[1] && hit[2]) |=> !pwm_o[1])
    else $error("double output missed its falling edge");

  chk_negative_fall : assert property (
    (st.pwm && st.dbl[3] && hit[4]) |=> !pwm_o[3])
    else $error("negative pulse output missed its falling edge");

  chk_reset_match : assert property (
    (|hit_rst) |=> (st.count == 32'h0000_0000))
    else $error("reset action did not clear the counter");

  chk_stop_freeze : assert property (
    (!st.run && !st.hold) |=> (st.count == $past(st.count)))
    else $error("stopped counter moved");

  chk_flag_clear : assert property (
    (wr_take && adr_i[7:2] == OFS_FLAGS[7:2] && sel_i[0] && dat_i[2] && !hit_irq[2]) |=> !st.flags[2])
    else $error("flag not cleared by writing one");

  chk_flag_source : assert property (
    !(|hit_irq) |=> ((st.flags & ~$past(st.flags)) == 7'h00))
    else $error("flag set without an enabled match");

  chk_latch_apply : assert property (
    (st.pwm && hit[0] && st.latch[1]) |=> (st.act[1] == $past(st.shadow[1])))
    else $error("released match value not applied at period match");

  chk_latch_clear : assert property (
    (st.pwm && hit[0] && st.latch[1] && !wr_take) |=> !st.latch[1])
    else $error("release bit not cleared after use");

  chk_plain_follow : assert property (
    !st.pwm |=> (st.act == $past(st.shadow)))
    else $error("plain timer match not loaded at once");

  chk_count_step : assert property (
    (tick && !st.hold && !(|hit_rst) && !(st.pwm && hit[0])) |=> (st.count == $past(st.count) + 32'h0000_0001))
    else $error("counter did not step on tick");

  chk_hold_zero : assert property (
    st.hold |=> (st.count == 32'h0000_0000))
    else $error("held counter not at zero");

  chk_count_idle : assert property (
    (!tick && !st.hold) |=> (st.count == $past(st.count)))
    else $error("counter moved without a prescaler tick");

endmodule : mmpt_timer
